// ==== rtl/org_consts.vh ====
// constants for the output rate generator: offsets, fields, resets, timing
`ifndef ORG_CONSTS_VH
`define ORG_CONSTS_VH

// register byte offsets
`define ORG_REG_RATIO_INT   8'h00
`define ORG_REG_RATIO_FRAC  8'h04
`define ORG_REG_TRANSFER    8'h08
`define ORG_REG_CHAN_DIV    8'h0c
`define ORG_REG_FILTER      8'h10
`define ORG_REG_SETTLE      8'h14
`define ORG_REG_STATUS      8'h18
`define ORG_REG_PERIOD      8'h1c

// field positions
`define ORG_TRANSFER_BIT    0
`define ORG_ST_MASTER       0
`define ORG_ST_SERIAL       1
`define ORG_ST_VALID        2
`define ORG_ST_UNSUP        3
`define ORG_ST_RANGE        4

// reset values
`define ORG_RATIO_INT_RST   24'h000040
`define ORG_RATIO_FRAC_RST  32'h00000000
`define ORG_CHAN_DIV_RST    8'h00
`define ORG_FILTER_RST      2'h2
`define ORG_SETTLE_RST      24'h000400

// filter codes
`define ORG_FILT_FIR        2'h0
`define ORG_FILT_SINC6      2'h1

// rate range in samples per second
`define ORG_MIN_SPS         10
`define ORG_MAX_SPS         1496000

// timing
`define ORG_CLK_PERIOD_NS   10
`define ORG_T_DELAY_NS      2000
`define ORG_CO_UNIT_US      500
`define ORG_RELOCK_PERIODS  24'h000200
`define ORG_TOL_SPS         500

// rate band edges in tenths of a sample per second
`define ORG_TRACK_DSPS      100000
`define ORG_B750K_DSPS      7500000
`define ORG_B374K_DSPS      3740000
`define ORG_B365K_DSPS      3650000
`define ORG_B1K46_DSPS      14600
`define ORG_B732_DSPS       7320
`define ORG_B366_DSPS       3660
`define ORG_B183_DSPS       1830
`define ORG_B91_DSPS        915
`define ORG_B45_DSPS        457
`define ORG_B22_DSPS        228
`define ORG_B11_DSPS        114

// change-over times in half-millisecond units
`define ORG_CO_5P5MS        19'd11
`define ORG_CO_11MS         19'd22
`define ORG_CO_22MS         19'd44
`define ORG_CO_44MS         19'd88
`define ORG_CO_88MS         19'd176
`define ORG_CO_6S           19'd12000
`define ORG_CO_12S          19'd24000
`define ORG_CO_24S          19'd48000
`define ORG_CO_48S          19'd96000
`define ORG_CO_96S          19'd192000
`define ORG_CO_192S         19'd384000

`endif

// ==== rtl/org_phase_acc.v ====
// integer-plus-fraction divider making the master rate tick
`timescale 1ns/1ns
module org_phase_acc #(
   parameter INT_W  = 24,
   parameter FRAC_W = 32
) (
   input  wire              clk_i,
   input  wire              nrst_i,
   input  wire              run_i,
   input  wire              load_i,
   input  wire [INT_W-1:0]  ratio_int_i,
   input  wire [FRAC_W-1:0] ratio_frac_i,
   output wire              tick_o
);
   reg  [INT_W:0]    cnt_ff;
   reg  [FRAC_W-1:0] acc_ff;
   reg               tick_ff;
   wire [FRAC_W:0]   nxt_acc;

   assign nxt_acc = {1'b0, acc_ff} + {1'b0, ratio_frac_i};
   assign tick_o  = tick_ff;

   // carry out of the fraction stretches the period by one cycle
   always @(posedge clk_i) begin
      if (!nrst_i || !run_i || load_i) begin
         cnt_ff  <= {1'b0, ratio_int_i};
         acc_ff  <= {FRAC_W{1'b0}};
         tick_ff <= 1'b0;
      end else if (cnt_ff <= {{INT_W{1'b0}}, 1'b1}) begin
         tick_ff <= 1'b1;
         acc_ff  <= nxt_acc[FRAC_W-1:0];
         cnt_ff  <= {1'b0, ratio_int_i} + {{INT_W{1'b0}}, nxt_acc[FRAC_W]};
      end else begin
         tick_ff <= 1'b0;
         cnt_ff  <= cnt_ff - {{INT_W{1'b0}}, 1'b1};
      end
   end
endmodule

// ==== rtl/org_rate_gen.v ====
// output rate strobe generator and slave rate tracker
`timescale 1ns/1ns
`include "org_consts.vh"
module org_rate_gen #(
   parameter [31:0] CLK_HZ      = 32'd100000000,
   parameter [31:0] CO_UNIT_CYC =
      (`ORG_CO_UNIT_US * 1000) / `ORG_CLK_PERIOD_NS,
   parameter        PER_W       = 24
) (
   input  wire        mclk_i,
   input  wire        nrst_i,
   input  wire        mode_strap_i,
   input  wire        ctrl_strap_i,
   input  wire        rate_select_bit0_i,
   input  wire        rate_select_bit1_i,
   input  wire        rate_select_bit2_i,
   input  wire        rate_select_bit3_i,
   input  wire [1:0]  filter_strap_i,
   input  wire        output_rate_strobe_i,
   output wire        output_rate_strobe_o,
   output wire        output_rate_strobe_oe_o,
   input  wire [7:0]  reg_addr_i,
   input  wire [31:0] reg_wdata_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   output wire [31:0] reg_rdata_o,
   output wire        word_strobe_o,
   output wire [3:0]  chan_strobe_o,
   output wire        data_valid_o
);
   localparam [5:0] S_IDLE   = 6'b000001;
   localparam [5:0] S_DELAY  = 6'b000010;
   localparam [5:0] S_CHG    = 6'b000100;
   localparam [5:0] S_P512   = 6'b001000;
   localparam [5:0] S_SETTLE = 6'b010000;
   localparam [5:0] S_RUN    = 6'b100000;

   localparam [31:0] DELAY32 = (`ORG_T_DELAY_NS + `ORG_CLK_PERIOD_NS - 1)
                               / `ORG_CLK_PERIOD_NS;
   localparam [31:0] RMIN32  = CLK_HZ / `ORG_MAX_SPS;
   localparam [31:0] RMAX32  = CLK_HZ / `ORG_MIN_SPS;

   // period in cycles of a rate given in tenths of a sample per second
   function [63:0] per_of;
      input [31:0] dsps;
      begin
         per_of = ({32'h0, CLK_HZ} * 64'd10) / {32'h0, dsps};
      end
   endfunction

   // strap rate table, in samples per second
   function [20:0] strap_sps;
      input [1:0] filt;
      input [3:0] code;
      reg   [20:0] a, b, c;
      begin
         a = 21'd0;
         b = 21'd0;
         c = 21'd0;
         case (code)
            4'h0: begin a = 21'd374000; b = 21'd1496000; c = 21'd1496000; end
            4'h1: begin a = 21'd325000; b = 21'd1250000; c = 21'd1000000; end
            4'h2: begin a = 21'd285000; b = 21'd1000000; c = 21'd750000;  end
            4'h3: begin a = 21'd256000; b = 21'd750000;  c = 21'd375000;  end
            4'h4: begin a = 21'd235000; b = 21'd500000;  c = 21'd187500;  end
            4'h5: begin a = 21'd200000; b = 21'd375000;  c = 21'd128000;  end
            4'h6: begin a = 21'd175000; b = 21'd325000;  c = 21'd64000;   end
            4'h7: begin a = 21'd128000; b = 21'd256000;  c = 21'd32000;   end
            4'h8: begin a = 21'd100000; b = 21'd175000;  c = 21'd16000;   end
            4'h9: begin a = 21'd80000;  b = 21'd128000;  c = 21'd5000;    end
            4'ha: begin a = 21'd64000;  b = 21'd80000;   c = 21'd2500;    end
            4'hb: begin a = 21'd32000;  b = 21'd64000;   c = 21'd1250;    end
            4'hc: begin a = 21'd16000;  b = 21'd32000;   c = 21'd625;     end
            4'hd: begin a = 21'd10000;  b = 21'd10000;   c = 21'd60;      end
            4'he: begin a = 21'd5000;   b = 21'd5000;    c = 21'd50;      end
            default: begin a = 21'd2500; b = 21'd2500;   c = 21'd10;      end
         endcase
         if (filt == `ORG_FILT_FIR)
            strap_sps = a;
         else if (filt == `ORG_FILT_SINC6)
            strap_sps = b;
         else
            strap_sps = c;
      end
   endfunction

   // change-over time by rate band, half-millisecond units
   function [18:0] co_units;
      input [PER_W-1:0] p;
      input             fir;
      reg   [63:0]      pp;
      begin
         pp = {{(64-PER_W){1'b0}}, p};
         if (fir)                                 co_units = `ORG_CO_22MS;
         else if (pp <= per_of(`ORG_B750K_DSPS))  co_units = `ORG_CO_5P5MS;
         else if (pp <= per_of(`ORG_B374K_DSPS))  co_units = `ORG_CO_11MS;
         else if (pp <= per_of(`ORG_B1K46_DSPS))  co_units = `ORG_CO_22MS;
         else if (pp <= per_of(`ORG_B732_DSPS))   co_units = `ORG_CO_44MS;
         else if (pp <= per_of(`ORG_B366_DSPS))   co_units = `ORG_CO_88MS;
         else if (pp <= per_of(`ORG_B183_DSPS))   co_units = `ORG_CO_6S;
         else if (pp <= per_of(`ORG_B91_DSPS))    co_units = `ORG_CO_12S;
         else if (pp <= per_of(`ORG_B45_DSPS))    co_units = `ORG_CO_24S;
         else if (pp <= per_of(`ORG_B22_DSPS))    co_units = `ORG_CO_48S;
         else if (pp <= per_of(`ORG_B11_DSPS))    co_units = `ORG_CO_96S;
         else                                     co_units = `ORG_CO_192S;
      end
   endfunction

   // true while a period change stays inside the tracking window
   function tol_ok;
      input [PER_W-1:0] p0;
      input [PER_W-1:0] p1;
      reg   [PER_W-1:0] d;
      reg   [63:0]      lhs;
      reg   [63:0]      rhs;
      begin
         d   = (p1 > p0) ? (p1 - p0) : (p0 - p1);
         lhs = {{(64-PER_W){1'b0}}, d} * {32'h0, CLK_HZ};
         rhs = {{(64-PER_W){1'b0}}, p0} * {{(64-PER_W){1'b0}}, p1}
               * 64'd`ORG_TOL_SPS;
         if ({{(64-PER_W){1'b0}}, p0} < per_of(`ORG_TRACK_DSPS))
            tol_ok = lhs < rhs;
         else
            tol_ok = d <= {{(PER_W-1){1'b0}}, 1'b1};
      end
   endfunction

   // channel divider mask: 1, 1/2, 1/4, 1/8
   function [2:0] div_mask;
      input [1:0] code;
      begin
         case (code)
            2'h0:    div_mask = 3'h0;
            2'h1:    div_mask = 3'h1;
            2'h2:    div_mask = 3'h3;
            default: div_mask = 3'h7;
         endcase
      end
   endfunction

   // pin synchronisers: {strobe, filter[1:0], rate sel[3:0], ctrl, mode}
   reg  [8:0]        sync1_ff;
   reg  [8:0]        sync2_ff;
   reg               strb_d_ff;
   reg  [1:0]        cap_cnt_ff;
   reg               captured_ff;
   reg               master_ff;
   reg               serial_ff;
   reg  [3:0]        dec_ff;
   reg  [23:0]       rint_ff;
   reg  [31:0]       rfrac_ff;
   reg  [7:0]        chdiv_ff;
   reg  [1:0]        filt_reg_ff;
   reg  [23:0]       settle_ff;
   reg  [31:0]       rdata_ff;
   reg  [23:0]       act_int_ff;
   reg  [31:0]       act_frac_ff;
   reg               load_ff;
   reg               range_ff;
   reg  [63:0]       dvd_ff;
   reg  [22:0]       rem_ff;
   reg  [55:0]       quo_ff;
   reg  [6:0]        div_cnt_ff;
   reg               div_busy_ff;
   reg               div_done_ff;
   reg               div_seen_ff;
   reg  [1:0]        filt_used_ff;
   reg  [20:0]       sps_ff;
   reg  [5:0]        state_ff;
   reg  [PER_W-1:0]  cnt_ff;
   reg  [PER_W-1:0]  per_cnt_ff;
   reg  [PER_W-1:0]  ref_ff;
   reg               have_ff;
   reg               ref_ok_ff;
   reg               unsup_ff;
   reg  [18:0]       units_ff;
   reg  [23:0]       pre_ff;
   reg  [2:0]        div3_ff;
   reg               strb_o_ff;
   reg               word_ff;
   reg  [3:0]        chan_ff;
   wire              acc_tick;
   wire              rise;
   wire              edge_ev;
   wire              xfer;
   wire [1:0]        filt_eff;
   wire [PER_W-1:0]  meas;
   wire [22:0]       rem_sh;
   wire              q_bit;
   wire              base_tick;
   integer           i;

   assign rise     = sync2_ff[8] & ~strb_d_ff;
   assign edge_ev  = captured_ff & ~master_ff & rise;
   assign xfer     = reg_wr_i & (reg_addr_i == `ORG_REG_TRANSFER)
                     & reg_wdata_i[`ORG_TRANSFER_BIT];
   assign filt_eff = serial_ff ? filt_reg_ff : sync2_ff[7:6];
   assign meas     = per_cnt_ff + {{(PER_W-1){1'b0}}, 1'b1};
   assign rem_sh   = {rem_ff[21:0], dvd_ff[63]};
   assign q_bit    = rem_sh >= {2'b00, sps_ff};
   assign base_tick = master_ff ? acc_tick : edge_ev;

   assign output_rate_strobe_o    = strb_o_ff;
   assign output_rate_strobe_oe_o = master_ff;
   assign reg_rdata_o             = rdata_ff;
   assign word_strobe_o           = word_ff;
   assign chan_strobe_o           = chan_ff;
   // one-hot run bit, so the pin comes straight from a flop
   assign data_valid_o            = state_ff[5];

   // strap capture waits for the synchronisers to fill, then freezes
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         sync1_ff    <= 9'h000;
         sync2_ff    <= 9'h000;
         strb_d_ff   <= 1'b0;
         cap_cnt_ff  <= 2'h0;
         captured_ff <= 1'b0;
         master_ff   <= 1'b0;
         serial_ff   <= 1'b0;
         dec_ff      <= 4'h0;
      end else begin
         sync1_ff  <= {output_rate_strobe_i, filter_strap_i,
                       rate_select_bit3_i, rate_select_bit2_i,
                       rate_select_bit1_i, rate_select_bit0_i,
                       ctrl_strap_i, mode_strap_i};
         sync2_ff  <= sync1_ff;
         strb_d_ff <= sync2_ff[8];
         if (cap_cnt_ff != 2'h2)
            cap_cnt_ff <= cap_cnt_ff + 2'h1;
         else if (!captured_ff) begin
            captured_ff <= 1'b1;
            master_ff   <= sync2_ff[0];
            serial_ff   <= sync2_ff[1];
            dec_ff      <= sync2_ff[5:2];
         end
      end
   end

   // register port, read data one cycle after the strobe
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         rint_ff     <= `ORG_RATIO_INT_RST;
         rfrac_ff    <= `ORG_RATIO_FRAC_RST;
         chdiv_ff    <= `ORG_CHAN_DIV_RST;
         filt_reg_ff <= `ORG_FILTER_RST;
         settle_ff   <= `ORG_SETTLE_RST;
         rdata_ff    <= 32'h00000000;
      end else begin
         if (reg_wr_i) begin
            case (reg_addr_i)
               `ORG_REG_RATIO_INT:  rint_ff     <= reg_wdata_i[23:0];
               `ORG_REG_RATIO_FRAC: rfrac_ff    <= reg_wdata_i;
               `ORG_REG_CHAN_DIV:   chdiv_ff    <= reg_wdata_i[7:0];
               `ORG_REG_FILTER:     filt_reg_ff <= reg_wdata_i[1:0];
               `ORG_REG_SETTLE:     settle_ff   <= reg_wdata_i[23:0];
               default: ;
            endcase
         end
         rdata_ff <= 32'h00000000;
         if (reg_rd_i) begin
            case (reg_addr_i)
               `ORG_REG_RATIO_INT:  rdata_ff <= {8'h00, rint_ff};
               `ORG_REG_RATIO_FRAC: rdata_ff <= rfrac_ff;
               `ORG_REG_CHAN_DIV:   rdata_ff <= {24'h000000, chdiv_ff};
               `ORG_REG_FILTER:     rdata_ff <= {30'h0, filt_reg_ff};
               `ORG_REG_SETTLE:     rdata_ff <= {8'h00, settle_ff};
               `ORG_REG_STATUS:
                  rdata_ff <= {27'h0, range_ff, unsup_ff, data_valid_o,
                               serial_ff, master_ff};
               `ORG_REG_PERIOD:
                  rdata_ff <= {{(32-PER_W){1'b0}}, ref_ff};
               default:             rdata_ff <= 32'h00000000;
            endcase
         end
      end
   end

   // serial divider turns the strap rate into a ratio; a strap filter
   // change restarts it, costing 64 cycles instead of a big comb divider
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         dvd_ff       <= 64'h0;
         rem_ff       <= 23'h0;
         quo_ff       <= 56'h0;
         div_cnt_ff   <= 7'h00;
         div_busy_ff  <= 1'b0;
         div_done_ff  <= 1'b0;
         div_seen_ff  <= 1'b0;
         filt_used_ff <= 2'h0;
         sps_ff       <= 21'h0;
      end else begin
         div_done_ff <= 1'b0;
         if (div_busy_ff) begin
            rem_ff     <= q_bit ? (rem_sh - {2'b00, sps_ff}) : rem_sh;
            quo_ff     <= {quo_ff[54:0], q_bit};
            dvd_ff     <= {dvd_ff[62:0], 1'b0};
            div_cnt_ff <= div_cnt_ff - 7'h01;
            if (div_cnt_ff == 7'h01) begin
               div_busy_ff <= 1'b0;
               div_done_ff <= 1'b1;
            end
         end else if (captured_ff && master_ff && !serial_ff &&
                      (!div_seen_ff || sync2_ff[7:6] != filt_used_ff)) begin
            div_busy_ff  <= 1'b1;
            div_seen_ff  <= 1'b1;
            filt_used_ff <= sync2_ff[7:6];
            sps_ff       <= strap_sps(sync2_ff[7:6], dec_ff);
            dvd_ff       <= {CLK_HZ, 32'h0};
            rem_ff       <= 23'h0;
            div_cnt_ff   <= 7'h40;
         end
      end
   end

   // active ratio changes only on trigger or fresh strap result
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         act_int_ff  <= `ORG_RATIO_INT_RST;
         act_frac_ff <= `ORG_RATIO_FRAC_RST;
         load_ff     <= 1'b0;
         range_ff    <= 1'b0;
      end else begin
         load_ff <= 1'b0;
         if (captured_ff && master_ff && serial_ff && xfer) begin
            load_ff <= 1'b1;
            if (rint_ff < RMIN32[23:0]) begin
               act_int_ff  <= RMIN32[23:0];
               act_frac_ff <= 32'h0;
               range_ff    <= 1'b1;
            end else if (rint_ff > RMAX32[23:0] ||
                         (rint_ff == RMAX32[23:0] && rfrac_ff != 32'h0)) begin
               act_int_ff  <= RMAX32[23:0];
               act_frac_ff <= 32'h0;
               range_ff    <= 1'b1;
            end else begin
               act_int_ff  <= rint_ff;
               act_frac_ff <= rfrac_ff;
               range_ff    <= 1'b0;
            end
         end else if (div_done_ff) begin
            load_ff     <= 1'b1;
            act_int_ff  <= quo_ff[55:32];
            act_frac_ff <= quo_ff[31:0];
            range_ff    <= 1'b0;
         end
      end
   end

   org_phase_acc #(
      .INT_W  (24),
      .FRAC_W (32)
   ) u_acc (
      .clk_i        (mclk_i),
      .nrst_i       (nrst_i),
      .run_i        (captured_ff & master_ff & div_seen_ff | serial_ff
                     & captured_ff & master_ff),
      .load_i       (load_ff),
      .ratio_int_i  (act_int_ff),
      .ratio_frac_i (act_frac_ff),
      .tick_o       (acc_tick)
   );

   // lock and data loss sequencing for both modes
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         state_ff   <= S_IDLE;
         cnt_ff     <= {PER_W{1'b0}};
         per_cnt_ff <= {PER_W{1'b0}};
         ref_ff     <= {PER_W{1'b0}};
         have_ff    <= 1'b0;
         ref_ok_ff  <= 1'b0;
         unsup_ff   <= 1'b0;
         units_ff   <= 19'h0;
         pre_ff     <= 24'h0;
      end else begin
         if (edge_ev)
            per_cnt_ff <= {PER_W{1'b0}};
         else if (per_cnt_ff != {PER_W{1'b1}})
            per_cnt_ff <= meas;
         if (load_ff) begin
            state_ff <= S_DELAY;
            cnt_ff   <= DELAY32[PER_W-1:0];
         end else if (edge_ev && !have_ff) begin
            have_ff <= 1'b1;
         end else if (edge_ev && (!ref_ok_ff || !tol_ok(ref_ff, meas))) begin
            ref_ok_ff <= 1'b1;
            ref_ff    <= meas;
            state_ff  <= S_CHG;
            units_ff  <= co_units(meas, filt_eff == `ORG_FILT_FIR);
            pre_ff    <= CO_UNIT_CYC[23:0];
            unsup_ff  <= (filt_eff == `ORG_FILT_FIR) &&
                         ({{(64-PER_W){1'b0}}, meas} <=
                          per_of(`ORG_B365K_DSPS));
         end else begin
            if (edge_ev)
               ref_ff <= meas;
            case (state_ff)
               S_IDLE: ;
               S_DELAY: begin
                  if (cnt_ff <= {{(PER_W-1){1'b0}}, 1'b1}) begin
                     state_ff <= S_SETTLE;
                     cnt_ff   <= settle_ff[PER_W-1:0];
                  end else
                     cnt_ff <= cnt_ff - {{(PER_W-1){1'b0}}, 1'b1};
               end
               S_CHG: begin
                  // unsupported rates hold here until the rate moves
                  if (!unsup_ff) begin
                     if (pre_ff <= 24'h1) begin
                        pre_ff <= CO_UNIT_CYC[23:0];
                        if (units_ff <= 19'h1) begin
                           state_ff <= S_P512;
                           cnt_ff   <= `ORG_RELOCK_PERIODS;
                        end else
                           units_ff <= units_ff - 19'h1;
                     end else
                        pre_ff <= pre_ff - 24'h1;
                  end
               end
               S_P512: begin
                  if (edge_ev) begin
                     if (cnt_ff <= {{(PER_W-1){1'b0}}, 1'b1}) begin
                        state_ff <= S_SETTLE;
                        cnt_ff   <= settle_ff[PER_W-1:0];
                     end else
                        cnt_ff <= cnt_ff - {{(PER_W-1){1'b0}}, 1'b1};
                  end
               end
               S_SETTLE: begin
                  if (cnt_ff <= {{(PER_W-1){1'b0}}, 1'b1})
                     state_ff <= S_RUN;
                  else
                     cnt_ff <= cnt_ff - {{(PER_W-1){1'b0}}, 1'b1};
               end
               S_RUN: ;
               default: state_ff <= S_IDLE;
            endcase
         end
      end
   end

   // word and per channel strobes share one base tick, the channels gated by one counter, so they align
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         div3_ff   <= 3'h0;
         strb_o_ff <= 1'b0;
         word_ff   <= 1'b0;
         chan_ff   <= 4'h0;
      end else begin
         strb_o_ff <= acc_tick & master_ff;
         word_ff   <= base_tick;
         if (base_tick)
            div3_ff <= div3_ff + 3'h1;
         for (i = 0; i < 4; i = i + 1)
            chan_ff[i] <= base_tick &
               ((div3_ff & div_mask(chdiv_ff[2*i +: 2])) == 3'h0);
      end
   end
endmodule

// ==== sim/org_pulse_src.sv ====
// host side pulse source pacing the converter in slave operation
`timescale 1ns/1ns
module org_pulse_src (
   input  wire        clk_i,
   input  wire        en_i,
   input  wire [15:0] per_i,
   output logic       pulse_o
);
   logic [15:0] cnt_ff = 16'h0;
   initial pulse_o = 1'b0;
   always @(posedge clk_i) begin
      // continuous train, never gapped while enabled
      cnt_ff <= (!en_i || cnt_ff == per_i - 16'h1) ? 16'h0
                : cnt_ff + 16'h1;
      pulse_o <= en_i && cnt_ff < per_i / 2;
   end
endmodule

// ==== sim/org_rate_gen_sva.sv ====
// port checker for the output rate generator
`timescale 1ns/1ns
module org_rate_gen_sva (
   input wire        mclk_i, nrst_i, ctrl_strap_i, reg_wr_i, reg_rd_i,
   input wire        output_rate_strobe_o, output_rate_strobe_oe_o,
   input wire        word_strobe_o, data_valid_o,
   input wire [7:0]  reg_addr_i,
   input wire [31:0] reg_wdata_i, reg_rdata_o,
   input wire [3:0]  chan_strobe_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   sequence trig_s;
      output_rate_strobe_oe_o && ctrl_strap_i && reg_wr_i &&
         reg_addr_i == 8'h08 && reg_wdata_i[0];
   endsequence
   pin_own_a: assert property (
      output_rate_strobe_o |-> output_rate_strobe_oe_o) else $error("pin");
   tick_gap_a: assert property (
      output_rate_strobe_o |=> !output_rate_strobe_o [*8]) else $error("gap");
   word_pace_a: assert property (
      output_rate_strobe_o |-> word_strobe_o) else $error("word");
   chan_sub_a: assert property (
      |chan_strobe_o |-> word_strobe_o) else $error("chan");
   trig_drop_a: assert property (
      trig_s |-> ##[1:3] !data_valid_o) else $error("drop");
   drop_hold_a: assert property (
      $fell(data_valid_o) |-> !data_valid_o [*8]) else $error("hold");
   trig_zero_a: assert property (
      reg_rd_i && reg_addr_i == 8'h08 |=> reg_rdata_o == 32'h0)
      else $error("trig");
   int_width_a: assert property (
      reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o[31:24] == 8'h00)
      else $error("width");
endmodule
bind org_rate_gen org_rate_gen_sva u_sva (.mclk_i(mclk_i), .nrst_i(nrst_i),
   .ctrl_strap_i(ctrl_strap_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .output_rate_strobe_o(output_rate_strobe_o),
   .output_rate_strobe_oe_o(output_rate_strobe_oe_o),
   .word_strobe_o(word_strobe_o), .data_valid_o(data_valid_o),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_rdata_o(reg_rdata_o), .chan_strobe_o(chan_strobe_o));

// ==== sim/org_rate_gen_tb.sv ====
// self-checking testbench for the output rate generator
`timescale 1ns/1ns
module org_rate_gen_tb;
   logic        clk = 0, rst_n = 0, mode = 1, ctrl = 1, src_en = 0;
   logic        wr = 0, rd = 0, so, oe, ws, dv, src, pin;
   logic [3:0]  dec = 0, cs;
   logic [1:0]  filt = 1;
   logic [7:0]  addr = 0;
   logic [15:0] per = 16'd100;
   logic [31:0] wdat = 0, rdat;
   int          mismatches = 0, samples_checked = 0, cyc = 0;
   assign pin = oe ? so : src;
   initial forever #5 clk = ~clk;
   org_rate_gen #(.CO_UNIT_CYC(32'd10)) u_org_rate_gen (.mclk_i(clk),
      .nrst_i(rst_n), .mode_strap_i(mode), .ctrl_strap_i(ctrl),
      .rate_select_bit0_i(dec[0]), .rate_select_bit1_i(dec[1]),
      .rate_select_bit2_i(dec[2]), .rate_select_bit3_i(dec[3]),
      .filter_strap_i(filt), .output_rate_strobe_i(pin),
      .output_rate_strobe_o(so), .output_rate_strobe_oe_o(oe),
      .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdat), .word_strobe_o(ws), .chan_strobe_o(cs),
      .data_valid_o(dv));
   org_pulse_src u_org_pulse_src (.clk_i(clk), .en_i(src_en),
      .per_i(per), .pulse_o(src));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic boot(input logic m, c);
      @(posedge clk);
      rst_n <= 1'b0;
      mode <= m;
      ctrl <= c;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdat, e);
   endtask
   // cycles spanned by k strobe periods
   task automatic gap(input int k, output int n);
      n = 0;
      @(posedge clk iff so === 1'b1);
      repeat (k) do begin
         @(posedge clk);
         n++;
      end while (so !== 1'b1);
   endtask
   task automatic t_serial;
      int n;
      int k[4];
      boot(1'b1, 1'b1);
      rd_chk(8'h00, 32'h40);
      rd_chk(8'h20, 32'h0);
      wr_reg(8'h14, 32'd10);
      wr_reg(8'h00, 32'd100);
      wr_reg(8'h08, 32'h1);
      repeat (190) @(posedge clk);
      #1 chk(dv, 1'b0);
      repeat (30) @(posedge clk);
      #1 chk(dv, 1'b1);
      gap(1, n);
      chk(n, 100);
      wr_reg(8'h00, 32'd200);
      gap(1, n);
      chk(n, 100);
      wr_reg(8'h04, 32'h80000000);
      wr_reg(8'h08, 32'h1);
      gap(4, n);
      chk(n, 802);
      wr_reg(8'h0c, 32'he4);
      k = '{default: 0};
      repeat (8) begin
         @(posedge clk iff ws === 1'b1);
         for (int i = 0; i < 4; i++) k[i] += cs[i];
      end
      for (int i = 0; i < 4; i++) chk(k[i], 8 >> i);
      rd_chk(8'h08, 32'h0);
      wr_reg(8'h00, 32'd10);
      wr_reg(8'h08, 32'h1);
      rd_chk(8'h18, 32'h13);
      gap(1, n);
      chk(n, 66);
   endtask
   task automatic t_pin;
      int n;
      boot(1'b1, 1'b0);
      repeat (100) @(posedge clk);
      gap(3, n);
      chk(n / 2, 100);
      dec <= 4'hf;
      filt <= 2'h0;
      repeat (300) @(posedge clk);
      gap(3, n);
      chk(n / 2, 401);
      chk(oe, 1'b1);
   endtask
   task automatic t_slave;
      int n;
      filt <= 2'h2;
      boot(1'b0, 1'b1);
      src_en <= 1'b1;
      n = 0;
      repeat (1000) @(posedge clk) n += ws;
      chk(n, 10);
      chk(oe, 1'b0);
      // relock spans the band time plus 512 pulses
      repeat (45000) @(posedge clk);
      #1 chk(dv, 1'b0);
      repeat (9000) @(posedge clk);
      #1 chk(dv, 1'b1);
      repeat (500) @(posedge clk);
      #1 chk(dv, 1'b1);
      wr_reg(8'h10, 32'h0);
      per <= 16'd101;
      repeat (300) @(posedge clk);
      #1 chk(dv, 1'b0);
      rd_chk(8'h18, 32'ha);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 70000) begin
         mismatches++;
         stop_test();
      end
   end
   initial begin
      t_serial();
      t_pin();
      t_slave();
      stop_test();
   end
endmodule
